/* design/bdgs_pkg.sv */
// Constants for the bridge driver gate status registers
package bdgs_pkg;
  localparam int NUM_BRIDGES = 4;
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 7;
  localparam logic [6:0] ADDR_DELAY_REG_STATUS = 7'h51;
  localparam logic [6:0] ADDR_OV_FLAGS = 7'h52;
  localparam logic [15:0] DELAY_REG_RESET = 16'h0000;
  localparam logic [15:0] OV_FLAGS_RESET = 16'h0000;
  // Bits kept across a restart
  localparam logic [15:0] DELAY_REG_RESTART_KEEP = 16'h00c1;
  localparam logic [15:0] OV_FLAGS_RESTART_KEEP = 16'h3fff;
  // Field positions, delay regulation status
  localparam int POS_PREDISCHARGE = 8;
  localparam int POS_PRECHARGE = 4;
  localparam int POS_DELAY_REG = 0;
  // Field positions, overvoltage flags
  localparam int POS_INT_SUPPLY_BRAKE = 13;
  localparam int POS_BRIDGE_SUPPLY_BRAKE = 12;
  localparam int POS_LS_BRAKE = 8;
  localparam int POS_NORMAL_OV = 0;
  localparam logic [11:0] DELAY_REG_USED = 12'hfff;
  localparam logic [1:0] GATE_CTRL_OFF0 = 2'h0;
  localparam logic [1:0] GATE_CTRL_OFF1 = 2'h1;
endpackage : bdgs_pkg

/* design/bdgs_status_regs.sv */
// Delay regulation status and drain-source overvoltage flag registers
`timescale 1ns/1ps
`default_nettype none
module bdgs_status_regs #(
  parameter int BRIDGES = bdgs_pkg::NUM_BRIDGES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic [1:0] adaptive_gate_control_select,
  input wire logic [3:0] bridge_pwm_enable,
  input wire logic [3:0] bridge_high_impedance,
  input wire logic [3:0] predischarge_at_limit,
  input wire logic [3:0] precharge_at_limit,
  input wire logic [3:0] turn_on_delay_regulated,
  input wire logic [3:0] turn_off_delay_regulated,
  input wire logic internal_supply_brake_event,
  input wire logic bridge_supply_brake_event,
  input wire logic [3:0] lowside_brake_overvoltage_event,
  input wire logic [3:0] lowside_overvoltage_event,
  input wire logic [3:0] highside_overvoltage_event,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic rd_valid
);
  // The field layout is fixed by the register map; other counts cannot be served
  if (BRIDGES != bdgs_pkg::NUM_BRIDGES) begin : g_bad_bridges
    $error("Bridge count must match the four-bridge register map");
  end
  if (bdgs_pkg::POS_PRECHARGE != bdgs_pkg::POS_DELAY_REG + BRIDGES) begin : g_bad_pchg
    $error("Precharge field overlaps the regulation field");
  end
  if (bdgs_pkg::POS_PREDISCHARGE != bdgs_pkg::POS_PRECHARGE + BRIDGES) begin : g_bad_pdchg
    $error("Predischarge field overlaps the precharge field");
  end
  if (bdgs_pkg::POS_LS_BRAKE != bdgs_pkg::POS_NORMAL_OV + 2 * BRIDGES) begin : g_bad_normal
    $error("Normal overvoltage field overlaps the braking field");
  end
  if (bdgs_pkg::POS_BRIDGE_SUPPLY_BRAKE != bdgs_pkg::POS_LS_BRAKE + BRIDGES) begin : g_bad_brake
    $error("Braking field overlaps the supply brake flag");
  end
  if (bdgs_pkg::REG_WIDTH != 16) begin : g_bad_width
    $error("Register width must be sixteen bits");
  end
  if (bdgs_pkg::ADDR_WIDTH != 7) begin : g_bad_addr
    $error("Address width must be seven bits");
  end

  // Event and status inputs come from the analog domain; synchronise all
  // Costs two cycles of latency; an event shorter than a clock may be missed
  localparam int SYNC_W = 4 + 9 * BRIDGES;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] raw;
  assign raw = {adaptive_gate_control_select, bridge_pwm_enable, bridge_high_impedance,
                predischarge_at_limit, precharge_at_limit, turn_on_delay_regulated,
                turn_off_delay_regulated, internal_supply_brake_event,
                bridge_supply_brake_event, lowside_brake_overvoltage_event,
                lowside_overvoltage_event, highside_overvoltage_event};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  logic [1:0] gate_ctrl_sel_s;
  logic [3:0] pwm_s, hiz_s, pdchg_s, pchg_s, ton_s, toff_s;
  logic [3:0] lsbrk_s, ls_s, hs_s;
  logic vsint_s, vs_s;
  assign {gate_ctrl_sel_s, pwm_s, hiz_s, pdchg_s, pchg_s, ton_s, toff_s, vsint_s, vs_s,
          lsbrk_s, ls_s, hs_s} = sync2_r;

  // Delay regulation status register
  logic [15:0] delay_reg_r;
  logic [15:0] delay_reg_nxt;
  logic adaptive_active;
  logic [3:0] clamp_ok;
  logic [3:0] predischarge_clamp_state;
  logic [3:0] precharge_clamp_state;
  logic [3:0] delay_in_regulation_flag;
  always_comb begin
    adaptive_active = (gate_ctrl_sel_s != bdgs_pkg::GATE_CTRL_OFF0) &&
                      (gate_ctrl_sel_s != bdgs_pkg::GATE_CTRL_OFF1);
    clamp_ok = pwm_s & ~hiz_s & {4{adaptive_active}};
    // Clamped reads 0 while adaptive control governs the bridge, and also wherever reset, soft reset or restart loads zero into the bit
    predischarge_clamp_state = ~(clamp_ok & pdchg_s);
    precharge_clamp_state = ~(clamp_ok & pchg_s);
    delay_in_regulation_flag = ton_s | toff_s;
    delay_reg_nxt = '0;
    delay_reg_nxt[bdgs_pkg::POS_PREDISCHARGE +: 4] = predischarge_clamp_state;
    delay_reg_nxt[bdgs_pkg::POS_PRECHARGE +: 4] = precharge_clamp_state;
    delay_reg_nxt[bdgs_pkg::POS_DELAY_REG +: 4] = delay_in_regulation_flag;
    if (soft_reset) begin
      delay_reg_nxt = bdgs_pkg::DELAY_REG_RESET;
    end else if (restart) begin
      delay_reg_nxt = delay_reg_r & bdgs_pkg::DELAY_REG_RESTART_KEEP;
    end
  end
  // Host writes never reach this register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay_reg_r <= bdgs_pkg::DELAY_REG_RESET;
    end else begin
      delay_reg_r <= delay_reg_nxt;
    end
  end

  // Delay status checks
  a_delay_reserved: assert property (@(posedge clk) disable iff (!rstn)
    delay_reg_r[15:12] == 4'h0) else $error("Delay status reserved bits set");
  a_clamp_off_adapt: assert property (@(posedge clk) disable iff (!rstn)
    (!adaptive_active && !soft_reset && !restart) |=> delay_reg_r[11:4] == 8'hff)
    else $error("Clamp bit low with adaptive control off");
  a_pdchg_clamp: assert property (@(posedge clk) disable iff (!rstn)
    (adaptive_active && pwm_s[0] && !hiz_s[0] && pdchg_s[0] && !soft_reset && !restart)
    |=> !delay_reg_r[8]) else $error("Predischarge clamp not reported");
  a_pchg_clamp: assert property (@(posedge clk) disable iff (!rstn)
    (adaptive_active && pwm_s[3] && !hiz_s[3] && pchg_s[3] && !soft_reset && !restart)
    |=> !delay_reg_r[7]) else $error("Precharge clamp not reported");
  a_delay_regulated: assert property (@(posedge clk) disable iff (!rstn)
    (!soft_reset && !restart) |=> delay_reg_r[3:0] == $past(ton_s | toff_s))
    else $error("Regulation flags wrong");
  a_restart_keep: assert property (@(posedge clk) disable iff (!rstn)
    (restart && !soft_reset) |=> delay_reg_r == ($past(delay_reg_r) & 16'h00c1))
    else $error("Restart kept wrong bits");
  a_soft_wins: assert property (@(posedge clk) disable iff (!rstn)
    (soft_reset && restart) |=> delay_reg_r == 16'h0000)
    else $error("Restart overrode soft reset");

  // Per-bridge checks; outside soft reset and restart, a bridge outside adaptive control must never report a clamp
  for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge
    a_pdchg_each: assert property (@(posedge clk) disable iff (!rstn)
      (adaptive_active && pwm_s[i] && !hiz_s[i] && pdchg_s[i] && !soft_reset && !restart)
      |=> !delay_reg_r[bdgs_pkg::POS_PREDISCHARGE + i])
      else $error("Predischarge clamp missing");
    a_pdchg_free: assert property (@(posedge clk) disable iff (!rstn)
      (!(adaptive_active && pwm_s[i] && !hiz_s[i] && pdchg_s[i]) && !soft_reset && !restart)
      |=> delay_reg_r[bdgs_pkg::POS_PREDISCHARGE + i])
      else $error("Predischarge clamp reported without cause");
    a_pchg_each: assert property (@(posedge clk) disable iff (!rstn)
      (adaptive_active && pwm_s[i] && !hiz_s[i] && pchg_s[i] && !soft_reset && !restart)
      |=> !delay_reg_r[bdgs_pkg::POS_PRECHARGE + i])
      else $error("Precharge clamp missing");
    a_pchg_free: assert property (@(posedge clk) disable iff (!rstn)
      (!(adaptive_active && pwm_s[i] && !hiz_s[i] && pchg_s[i]) && !soft_reset && !restart)
      |=> delay_reg_r[bdgs_pkg::POS_PRECHARGE + i])
      else $error("Precharge clamp reported without cause");
    a_pwm_off_free: assert property (@(posedge clk) disable iff (!rstn)
      (!pwm_s[i] && !soft_reset && !restart) |=> (delay_reg_r[bdgs_pkg::POS_PREDISCHARGE + i]
      && delay_reg_r[bdgs_pkg::POS_PRECHARGE + i]))
      else $error("Clamp reported with PWM off");
    a_hiz_free: assert property (@(posedge clk) disable iff (!rstn)
      (hiz_s[i] && !soft_reset && !restart) |=> (delay_reg_r[bdgs_pkg::POS_PREDISCHARGE + i]
      && delay_reg_r[bdgs_pkg::POS_PRECHARGE + i]))
      else $error("Clamp reported with bridge high impedance");
    a_reg_set: assert property (@(posedge clk) disable iff (!rstn)
      ((ton_s[i] || toff_s[i]) && !soft_reset && !restart)
      |=> delay_reg_r[bdgs_pkg::POS_DELAY_REG + i])
      else $error("Regulation not reported");
    a_reg_clear: assert property (@(posedge clk) disable iff (!rstn)
      (!ton_s[i] && !toff_s[i] && !soft_reset && !restart)
      |=> !delay_reg_r[bdgs_pkg::POS_DELAY_REG + i])
      else $error("Regulation reported without cause");
  end

  // Overvoltage flags, sticky until read
  logic [15:0] ov_r;
  logic [15:0] ov_nxt;
  logic [15:0] ov_set;
  logic ov_read;
  always_comb begin
    ov_set = '0;
    ov_set[bdgs_pkg::POS_INT_SUPPLY_BRAKE] = vsint_s;
    ov_set[bdgs_pkg::POS_BRIDGE_SUPPLY_BRAKE] = vs_s;
    ov_set[bdgs_pkg::POS_LS_BRAKE +: 4] = lsbrk_s;
    for (int i = 0; i < 4; i++) begin
      ov_set[bdgs_pkg::POS_NORMAL_OV + 2*i + 1] = ls_s[i];
      ov_set[bdgs_pkg::POS_NORMAL_OV + 2*i] = hs_s[i];
    end
    ov_read = rd_en && (addr == bdgs_pkg::ADDR_OV_FLAGS);
    // Set wins over the read clear so a coincident event is kept
    ov_nxt = ((ov_read ? 16'h0000 : ov_r) | ov_set) & bdgs_pkg::OV_FLAGS_RESTART_KEEP;
    if (soft_reset) begin
      ov_nxt = bdgs_pkg::OV_FLAGS_RESET;
    end else if (restart) begin
      ov_nxt = ov_r & bdgs_pkg::OV_FLAGS_RESTART_KEEP;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_r <= bdgs_pkg::OV_FLAGS_RESET;
    end else begin
      ov_r <= ov_nxt;
    end
  end

  // Overvoltage flag checks
  a_ov_reserved: assert property (@(posedge clk) disable iff (!rstn)
    ov_r[15:14] == 2'h0) else $error("Overvoltage reserved bits set");
  a_ov_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (ov_r[13] && !ov_read && !soft_reset) |=> ov_r[13])
    else $error("Overvoltage flag lost before read");
  a_ov_set: assert property (@(posedge clk) disable iff (!rstn)
    (vs_s && !soft_reset && !restart) |=> ov_r[12]) else $error("Brake flag not set");
  a_int_brake_set: assert property (@(posedge clk) disable iff (!rstn)
    (vsint_s && !soft_reset && !restart) |=> ov_r[13]) else $error("Internal brake not set");
  a_ov_clear: assert property (@(posedge clk) disable iff (!rstn)
    (ov_read && ov_set == 16'h0000 && !soft_reset && !restart) |=> ov_r == 16'h0000)
    else $error("Read did not clear flags");
  a_ov_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    (ov_read && ov_set != 16'h0000 && !soft_reset && !restart)
    |=> (ov_r & $past(ov_set)) == $past(ov_set)) else $error("Read clear beat a new event");
  a_restart_ov_keep: assert property (@(posedge clk) disable iff (!rstn)
    (restart && !soft_reset) |=> ov_r == $past(ov_r)) else $error("Restart changed flags");
  a_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
    soft_reset |=> (ov_r == 16'h0000 && delay_reg_r == 16'h0000))
    else $error("Soft reset did not clear");
  for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge_ov
    a_lsbrk_set: assert property (@(posedge clk) disable iff (!rstn)
      (lsbrk_s[i] && !soft_reset && !restart) |=> ov_r[bdgs_pkg::POS_LS_BRAKE + i])
      else $error("Braking overvoltage not latched");
    a_ls_set: assert property (@(posedge clk) disable iff (!rstn)
      (ls_s[i] && !soft_reset && !restart) |=> ov_r[bdgs_pkg::POS_NORMAL_OV + 2*i + 1])
      else $error("Low-side overvoltage not latched");
    a_hs_set: assert property (@(posedge clk) disable iff (!rstn)
      (hs_s[i] && !soft_reset && !restart) |=> ov_r[bdgs_pkg::POS_NORMAL_OV + 2*i])
      else $error("High-side overvoltage not latched");
  end
  // Each latched flag holds until read and clears on a read with no new event
  for (genvar b = 0; b <= bdgs_pkg::POS_INT_SUPPLY_BRAKE; b++) begin : g_flag
    a_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
      (ov_r[b] && !ov_read && !soft_reset) |=> ov_r[b])
      else $error("Flag dropped before read");
    a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
      (ov_read && !ov_set[b] && !soft_reset && !restart) |=> !ov_r[b])
      else $error("Flag kept after read");
  end

  // Read port, one cycle latency
  // Unmapped addresses read zero; the host has no error path to report them
  logic [15:0] rdata_nxt;
  logic rd_valid_nxt;
  always_comb begin
    rdata_nxt = rdata;
    rd_valid_nxt = rd_en;
    if (rd_en) begin
      case (addr)
        bdgs_pkg::ADDR_DELAY_REG_STATUS: rdata_nxt = delay_reg_r;
        bdgs_pkg::ADDR_OV_FLAGS: rdata_nxt = ov_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rdata <= rdata_nxt;
      rd_valid <= rd_valid_nxt;
    end
  end

  logic unused_wr;
  assign unused_wr = wr_en ^ (^wdata);

  // Read port checks
  a_rd_valid_follow: assert property (@(posedge clk) disable iff (!rstn)
    rd_en |=> rd_valid)
    else $error("Read not answered");
  a_rd_valid_idle: assert property (@(posedge clk) disable iff (!rstn)
    !rd_en |=> !rd_valid)
    else $error("Answer without a read");
  a_rd_delay_data: assert property (@(posedge clk) disable iff (!rstn)
    (rd_en && addr == bdgs_pkg::ADDR_DELAY_REG_STATUS) |=> rdata == $past(delay_reg_r))
    else $error("Delay status read wrong");
  a_rd_ov_data: assert property (@(posedge clk) disable iff (!rstn)
    (rd_en && addr == bdgs_pkg::ADDR_OV_FLAGS) |=> rdata == $past(ov_r))
    else $error("Overvoltage read wrong");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!rstn)
    (rd_en && addr != bdgs_pkg::ADDR_DELAY_REG_STATUS && addr != bdgs_pkg::ADDR_OV_FLAGS)
    |=> rdata == 16'h0000) else $error("Unmapped read not zero");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
    !rd_en |=> $stable(rdata))
    else $error("Read data changed without a read");
endmodule : bdgs_status_regs
`default_nettype wire

/* verif/bdgs_host.sv */
// Host model issuing register read and write strobes
`timescale 1ns/1ps
`default_nettype none
module bdgs_host (
  input wire logic clk,
  input wire logic [15:0] rdata,
  input wire logic rd_valid,
  output logic rd_en,
  output logic wr_en,
  output logic [6:0] addr,
  output logic [15:0] wdata
);
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 7'h7f;
    wdata = 16'h0000;
  end
  // Released address shows the inverse, so a stale decode cannot pass
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk) #1;
    rd_en = 1'b1;
    addr = a;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk) #1;
      rd_en = 1'b0;
      addr = ~a;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
    end
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge clk) #1;
    wr_en = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk) #1;
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask : wr
endmodule : bdgs_host
`default_nettype wire

/* verif/test_bdgs_status_regs.sv */
// Self-checking bench for the gate status registers
`timescale 1ns/1ps
`default_nettype none
module test_bdgs_status_regs;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic srst = 1'b0;
  logic rsta = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [3:0] pwm = 4'h0, hiz = 4'h0, pdl = 4'h0, pcl = 4'h0, ton = 4'h0, tof = 4'h0;
  logic isb = 1'b0, bsb = 1'b0;
  logic [3:0] lsb = 4'h0, lso = 4'h0, hso = 4'h0;
  logic rd_en, wr_en, rd_valid;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  int miscompares = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  bdgs_status_regs u_dut (.clk(clk), .rstn(rstn), .soft_reset(srst), .restart(rsta),
    .adaptive_gate_control_select(sel), .bridge_pwm_enable(pwm),
    .bridge_high_impedance(hiz), .predischarge_at_limit(pdl), .precharge_at_limit(pcl),
    .turn_on_delay_regulated(ton), .turn_off_delay_regulated(tof),
    .internal_supply_brake_event(isb), .bridge_supply_brake_event(bsb),
    .lowside_brake_overvoltage_event(lsb), .lowside_overvoltage_event(lso),
    .highside_overvoltage_event(hso), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));
  bdgs_host u_host (.clk(clk), .rdata(rdata), .rd_valid(rd_valid), .rd_en(rd_en),
    .wr_en(wr_en), .addr(addr), .wdata(wdata));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic chk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    comparisons++;
    if (ok !== 1'b1 || d !== e) begin
      miscompares++;
      $display("MISMATCH reg %h expected %h seen %h", a, e, d);
    end
    if (ok !== 1'b1) begin
      conclude();
    end
  endtask : chk
  // Short event pulse, then time for the two-flop sync to land
  task automatic ev(input logic i, b, input logic [3:0] l, o, h);
    {isb, bsb, lsb, lso, hso} = {i, b, l, o, h};
    w(2);
    {isb, bsb, lsb, lso, hso} = 14'h0000;
    w(4);
  endtask : ev
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    w(6);
    rstn = 1'b1;
    w(4);
    chk(7'h51, 16'h0ff0);
    chk(7'h52, 16'h0000);
    chk(7'h50, 16'h0000);
    $display("test reset done");
    {sel, pwm, pdl, pcl, ton, tof} = {2'h2, 4'hf, 4'h5, 4'ha, 4'h1, 4'h4};
    w(4);
    chk(7'h51, 16'h0a55);
    u_host.wr(7'h51, 16'hffff);
    chk(7'h51, 16'h0a55);
    {sel, hiz, pwm} = {2'h3, 4'h1, 4'hb};
    w(4);
    chk(7'h51, 16'h0f55);
    {sel, hiz, pwm} = {2'h1, 4'h0, 4'hf};
    w(4);
    chk(7'h51, 16'h0ff5);
    $display("test clamp done");
    ev(1'b1, 1'b0, 4'h2, 4'h8, 4'h1);
    chk(7'h52, 16'h2281);
    chk(7'h52, 16'h0000);
    ev(1'b0, 1'b1, 4'hd, 4'h7, 4'he);
    chk(7'h52, 16'h1d7e);
    lso = 4'h8;
    w(4);
    chk(7'h52, 16'h0080);
    chk(7'h52, 16'h0080);
    lso = 4'h0;
    w(4);
    chk(7'h52, 16'h0080);
    chk(7'h52, 16'h0000);
    $display("test flags done");
    sel = 2'h2;
    ev(1'b1, 1'b0, 4'h2, 4'h8, 4'h1);
    rsta = 1'b1;
    w(3);
    chk(7'h51, 16'h0041);
    rsta = 1'b0;
    chk(7'h52, 16'h2281);
    $display("test restart done");
    ev(1'b0, 1'b1, 4'hd, 4'h7, 4'he);
    {srst, rsta} = 2'b11;
    w(3);
    chk(7'h51, 16'h0000);
    chk(7'h52, 16'h0000);
    {srst, rsta} = 2'b00;
    $display("test soft reset done");
    conclude();
  end
endmodule : test_bdgs_status_regs
`default_nettype wire
